// *** stop_pkg.sv ***
// Package with the constants of the stop-mode controller.
package stop_pkg;

	// Register byte addresses on the AXI4-Lite slave.
	localparam logic [3:0] ctrl_addr = 4'h0;
	localparam logic [3:0] status_addr = 4'h4;
	localparam logic [3:0] ack_addr = 4'h8;

	// Control register field positions.
	localparam int stop_enable_bit = 0;
	localparam int debug_enable_bit = 1;
	localparam int lvd_enable_bit = 2;
	localparam int lvd_stop_enable_bit = 3;
	localparam int ppd_select_bit = 4;
	localparam int irc_enable_bit = 5;
	localparam int irc_stop_enable_bit = 6;
	localparam int erc_enable_bit = 7;
	localparam int erc_stop_enable_bit = 8;
	localparam int erc_high_range_bit = 9;
	localparam int adc_async_clock_bit = 10;
	localparam int analog_comparator_bandgap_bit = 11;
	localparam int ctrl_width = 12;

	// Acknowledge register field position.
	localparam int ppd_ack_bit = 0;

	// Values after reset.
	localparam logic [ctrl_width-1:0] ctrl_reset = 12'h001;

	// Bus responses.
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	// Debug status codes for accepted commands and for commands refused while stopped.
	localparam logic [1:0] dbg_ok = 2'h0;
	localparam logic [1:0] dbg_err_stopped = 2'h1;

	typedef enum {
		run_st,
		stop3_st,
		stop2_st
	} mode_e;

endpackage : stop_pkg

// *** stop_mode_controller.sv ***
// Stop-mode selection, clock gating, pin latching and wake-up control.
// Notes on behaviour
// - Stop disabled: stop instruction gives illegal-opcode reset.
// - Debug enabled selects stop3 with debug logic.
// - Both detector bits select stop3, regulator active.
// - Otherwise partial powerdown select picks stop3 or stop2.
// - Any stop halts bus and CPU clocks.
// - Stop3 keeps registers, RAM and pin states.
// - Stop3 exits on reset pin or interrupts.
// - Interrupt exit of stop3 takes its vector.
// - Both detector bits keep regulator on throughout stop.
// - Converter and comparator need detector at stop3 entry.
// - Debug enabled keeps debug clocks and full regulation.
// - Status memory commands refused with stopped error.
// - Debug-entry command wakes stop into background mode.
// - Stop2 latches pins, powers off all but RAM.
// - Stop2 exits only by reset pin or counter.
// - Stop2 wake-up behaves as power-on reset.
// - Stop2 wake sets flag, pins latched until ack.
// - Peripheral clocks stop in every stop mode.
// - Debug or detector-stop turns stop2 into stop3.
// - External oscillator runs in stop3 only when enabled.
// - Internal reference runs in stop3 only when enabled.
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module stop_mode_controller
	import stop_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [3:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic stop_instr,
	input wire logic reset_pin_n,
	input wire logic wake_irq,
	input wire logic rtc_wake,
	input wire logic rtc_stop2_wake_enable,
	input wire logic debug_enable,
	input wire logic debug_entry_cmd,
	input wire logic debug_status_cmd,
	output logic debug_cmd_refused,
	output logic [1:0] debug_cmd_status,
	output logic illegal_opcode_reset,
	output logic por_reset,
	output logic take_irq_vector,
	output logic enter_background,
	output logic bus_clock_en,
	output logic cpu_clock_en,
	output logic periph_clock_en,
	output logic debug_clock_en,
	output logic regulator_active,
	output logic ram_only_power,
	output logic pin_latch,
	output logic partial_powerdown_flag,
	output logic adc_run_in_stop,
	output logic analog_comparator_bandgap_in_stop,
	output logic ext_osc_run,
	output logic int_ref_run,
	output logic [1:0] stop_mode
);

	typedef struct packed {
		mode_e mode;
		logic [ctrl_width-1:0] ctrl;
		logic dbg_at_entry;
		logic lvd_at_entry;
		logic ppd_flag;
		logic latch;
		logic ill_rst;
		logic por;
		logic irq_vec;
		logic bgnd;
		logic refused;
		logic aw_got;
		logic [3:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rpin_m;
		logic rpin_s;
		logic rtc_m;
		logic rtc_s;
	} state_s;

	state_s st_reg;
	state_s st_next;

	// Decodes whether a byte address names a register of this block.
	function automatic logic addr_mapped(input logic [3:0] a);
		return a == ctrl_addr || a == status_addr || a == ack_addr;
	endfunction : addr_mapped

	logic do_write;
	logic do_read;
	logic ack_write;
	logic stopped;
	logic rpin_asserted;

	assign stopped = st_reg.mode != run_st;
	assign rpin_asserted = !st_reg.rpin_s;
	assign do_write = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
	assign do_read = s_axi_arvalid && !st_reg.rvalid;
	assign ack_write = do_write && st_reg.aw_addr == ack_addr
		&& st_reg.w_strb[0] && st_reg.w_data[ppd_ack_bit];

	assign s_axi_awready = !st_reg.aw_got;
	assign s_axi_wready = !st_reg.w_got;
	assign s_axi_arready = !st_reg.rvalid;

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		st_next = st_reg;
		st_next.rpin_m = reset_pin_n;
		st_next.rpin_s = st_reg.rpin_m;
		st_next.rtc_m = rtc_wake;
		st_next.rtc_s = st_reg.rtc_m;
		st_next.ill_rst = 1'b0;
		st_next.por = 1'b0;
		st_next.irq_vec = 1'b0;
		st_next.bgnd = 1'b0;
		st_next.refused = 1'b0;

		if (s_axi_awvalid && !st_reg.aw_got) begin
			st_next.aw_got = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_reg.w_got) begin
			st_next.w_got = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = addr_mapped(st_reg.aw_addr) ? resp_okay : resp_slverr;
			if (st_reg.aw_addr == ctrl_addr) begin
				if (st_reg.w_strb[0])
					st_next.ctrl[7:0] = st_reg.w_data[7:0];
				if (st_reg.w_strb[1])
					st_next.ctrl[ctrl_width-1:8] = st_reg.w_data[ctrl_width-1:8];
			end
		end
		if (st_reg.bvalid && s_axi_bready)
			st_next.bvalid = 1'b0;
		if (do_read) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = addr_mapped(s_axi_araddr) ? resp_okay : resp_slverr;
			st_next.rdata = 32'h0;
			if (s_axi_araddr == ctrl_addr)
				st_next.rdata[ctrl_width-1:0] = st_reg.ctrl;
			else if (s_axi_araddr == status_addr)
				st_next.rdata[3:0] = {st_reg.latch, st_reg.ppd_flag,
					2'(stop_mode)};
		end
		if (st_reg.rvalid && s_axi_rready)
			st_next.rvalid = 1'b0;

		// Ack releases latches and flag together in the write cycle.
		if (ack_write) begin
			st_next.ppd_flag = 1'b0;
			st_next.latch = 1'b0;
		end

		case (st_reg.mode)
			run_st: begin
				if (stop_instr) begin
					st_next.dbg_at_entry = debug_enable;
					st_next.lvd_at_entry = st_reg.ctrl[lvd_enable_bit]
						&& st_reg.ctrl[lvd_stop_enable_bit];
					if (!st_reg.ctrl[stop_enable_bit])
						st_next.ill_rst = 1'b1;
					else if (debug_enable)
						st_next.mode = stop3_st;
					else if (st_reg.ctrl[lvd_enable_bit]
						&& st_reg.ctrl[lvd_stop_enable_bit])
						st_next.mode = stop3_st;
					else if (st_reg.ctrl[lvd_stop_enable_bit])
						st_next.mode = stop3_st;
					else if (st_reg.ctrl[ppd_select_bit]) begin
						st_next.mode = stop2_st;
						st_next.latch = 1'b1;
					end else
						st_next.mode = stop3_st;
				end
			end
			stop3_st: begin
				if (rpin_asserted) begin
					st_next.mode = run_st;
					st_next.por = 1'b1;
				end else if (st_reg.dbg_at_entry && debug_entry_cmd) begin
					st_next.mode = run_st;
					st_next.bgnd = 1'b1;
				end else if (wake_irq) begin
					st_next.mode = run_st;
					st_next.irq_vec = 1'b1;
				end
			end
			stop2_st: begin
				// Everything but RAM restarts from reset; ctrl returns to default.
				if (rpin_asserted || (rtc_stop2_wake_enable && st_reg.rtc_s)) begin
					st_next.mode = run_st;
					st_next.por = 1'b1;
					st_next.ctrl = ctrl_reset;
					st_next.ppd_flag = 1'b1;
				end
			end
			default: st_next.mode = run_st;
		endcase

		if (stopped && debug_status_cmd)
			st_next.refused = 1'b1;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.mode <= run_st;
			st_reg.ctrl <= ctrl_reset;
			st_reg.rpin_m <= 1'b1;
			st_reg.rpin_s <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////

	logic s3;
	assign s3 = st_reg.mode == stop3_st;

	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign illegal_opcode_reset = st_reg.ill_rst;
	assign por_reset = st_reg.por;
	assign take_irq_vector = st_reg.irq_vec;
	assign enter_background = st_reg.bgnd;
	assign debug_cmd_refused = st_reg.refused;
	assign debug_cmd_status = st_reg.refused ? dbg_err_stopped : dbg_ok;
	assign bus_clock_en = !stopped;
	assign cpu_clock_en = !stopped;
	// Stop3 holds state simply by gating clocks, never by reset.
	assign periph_clock_en = !stopped;
	assign debug_clock_en = !stopped || (s3 && st_reg.dbg_at_entry);
	assign regulator_active = !stopped
		|| (s3 && (st_reg.dbg_at_entry || st_reg.lvd_at_entry));
	assign ram_only_power = st_reg.mode == stop2_st;
	assign pin_latch = st_reg.latch;
	assign partial_powerdown_flag = st_reg.ppd_flag;
	assign adc_run_in_stop = s3 && st_reg.lvd_at_entry
		&& st_reg.ctrl[adc_async_clock_bit];
	assign analog_comparator_bandgap_in_stop = s3 && st_reg.lvd_at_entry
		&& st_reg.ctrl[analog_comparator_bandgap_bit];
	assign ext_osc_run = !stopped || (s3 && st_reg.ctrl[erc_enable_bit]
		&& st_reg.ctrl[erc_stop_enable_bit]
		&& (!st_reg.ctrl[erc_high_range_bit] || st_reg.lvd_at_entry));
	assign int_ref_run = !stopped || (s3 && st_reg.ctrl[irc_enable_bit]
		&& st_reg.ctrl[irc_stop_enable_bit]);
	assign stop_mode = s3 ? 2'h1 : (st_reg.mode == stop2_st ? 2'h2 : 2'h0);

	////////////////////////////////////////////////////////////////////////

	sequence stop_disabled_s;
		st_reg.mode == run_st && stop_instr && !st_reg.ctrl[stop_enable_bit];
	endsequence

	property no_stop_p;
		@(posedge clock) disable iff (rst)
		stop_disabled_s |=> illegal_opcode_reset && stop_mode == 2'h0;
	endproperty
	illegal_stop_a: assert property (no_stop_p)
		else $error("Disabled stop did not raise illegal reset.");

	debug_stop3_a: assert property (@(posedge clock) disable iff (rst)
		st_reg.mode == run_st && stop_instr && st_reg.ctrl[stop_enable_bit]
		&& debug_enable |=> stop_mode == 2'h1 && debug_clock_en)
		else $error("Debug stop did not select stop3.");

	lvd_stop3_a: assert property (@(posedge clock) disable iff (rst)
		st_reg.mode == run_st && stop_instr && st_reg.ctrl[stop_enable_bit]
		&& st_reg.ctrl[lvd_enable_bit] && st_reg.ctrl[lvd_stop_enable_bit]
		|=> stop_mode == 2'h1 && regulator_active)
		else $error("Detector stop did not keep regulator.");

	stop2_select_a: assert property (@(posedge clock) disable iff (rst)
		st_reg.mode == run_st && stop_instr && st_reg.ctrl[stop_enable_bit]
		&& !debug_enable && !st_reg.ctrl[lvd_stop_enable_bit]
		&& st_reg.ctrl[ppd_select_bit] |=> stop_mode == 2'h2 && pin_latch)
		else $error("Partial powerdown did not enter stop2.");

	clocks_halted_a: assert property (@(posedge clock) disable iff (rst)
		stop_mode != 2'h0 |-> !bus_clock_en && !cpu_clock_en
		&& !periph_clock_en)
		else $error("Clocks run during stop.");

	refuse_status_a: assert property (@(posedge clock) disable iff (rst)
		stopped && debug_status_cmd |=> debug_cmd_refused
		&& debug_cmd_status == dbg_err_stopped)
		else $error("Status command not refused in stop.");

	stop2_wake_a: assert property (@(posedge clock) disable iff (rst)
		st_reg.mode == stop2_st && rpin_asserted
		|=> por_reset && partial_powerdown_flag && pin_latch)
		else $error("Stop2 wake did not set flag.");

	ack_release_a: assert property (@(posedge clock) disable iff (rst)
		ack_write && !(st_reg.mode == stop2_st)
		|=> !pin_latch && !partial_powerdown_flag)
		else $error("Ack did not release pins.");

	irq_wake_a: assert property (@(posedge clock) disable iff (rst)
		s3 && !rpin_asserted && !(st_reg.dbg_at_entry && debug_entry_cmd)
		&& wake_irq |=> take_irq_vector && !por_reset)
		else $error("Interrupt wake did not take vector.");

endmodule : stop_mode_controller

// *** stop_partner.sv ***
// Far-side model of the CPU core, debug controller and peripherals.
`timescale 1ns/1ps
module stop_partner (
	input wire logic clock,
	input wire logic rst,
	input wire logic [3:0] req,
	input wire logic take_irq_vector,
	output logic stop_instr,
	output logic wake_irq,
	output logic debug_entry_cmd,
	output logic debug_status_cmd
);
	// A peripheral keeps its request up until its vector is taken.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			stop_instr <= 1'b0;
			wake_irq <= 1'b0;
			debug_entry_cmd <= 1'b0;
			debug_status_cmd <= 1'b0;
		end else begin
			stop_instr <= req[0];
			debug_entry_cmd <= req[2];
			debug_status_cmd <= req[3];
			if (req[1]) begin
				wake_irq <= 1'b1;
			end else if (take_irq_vector) begin
				wake_irq <= 1'b0;
			end
		end
	end
endmodule : stop_partner

// *** stop_mode_controller_bench.sv ***
// Testbench of the stop-mode controller.
`timescale 1ns/1ps
module stop_mode_controller_bench;
	import stop_pkg::*;
	logic clock, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, stop_instr;
	logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr, req;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0] s_axi_bresp, s_axi_rresp, debug_cmd_status, stop_mode, r;
	logic reset_pin_n, wake_irq, rtc_wake, rtc_stop2_wake_enable;
	logic debug_enable, debug_entry_cmd, debug_status_cmd, debug_cmd_refused;
	logic illegal_opcode_reset, por_reset, take_irq_vector, enter_background;
	logic bus_clock_en, cpu_clock_en, periph_clock_en, debug_clock_en;
	logic regulator_active, ram_only_power, pin_latch, partial_powerdown_flag;
	logic adc_run_in_stop, analog_comparator_bandgap_in_stop, ext_osc_run, int_ref_run;
	int errors = 0;
	int comparisons = 0;
	wire [7:0] ev = {debug_cmd_refused, enter_background, take_irq_vector,
		por_reset, illegal_opcode_reset, stop_mode == 2'h2,
		stop_mode == 2'h1, stop_mode == 2'h0};

	stop_mode_controller u_dut (.clock, .rst, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .stop_instr, .reset_pin_n,
		.wake_irq, .rtc_wake, .rtc_stop2_wake_enable, .debug_enable,
		.debug_entry_cmd, .debug_status_cmd, .debug_cmd_refused,
		.debug_cmd_status, .illegal_opcode_reset, .por_reset, .take_irq_vector,
		.enter_background, .bus_clock_en, .cpu_clock_en, .periph_clock_en,
		.debug_clock_en, .regulator_active, .ram_only_power, .pin_latch,
		.partial_powerdown_flag, .adc_run_in_stop, .analog_comparator_bandgap_in_stop,
		.ext_osc_run, .int_ref_run, .stop_mode);
	stop_partner u_partner (.clock, .rst, .req, .take_irq_vector,
		.stop_instr, .wake_irq, .debug_entry_cmd, .debug_status_cmd);

	always #25 clock = ~clock;

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("counts: %0d comparisons, %0d errors", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check

	// Bus handshakes are judged at 1 ns past the edge, where they are settled.
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		logic aw_ok, w_ok, b_ok;
		logic [1:0] br;
		@(posedge clock);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= v;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			#1;
			aw_ok = s_axi_awvalid && s_axi_awready;
			w_ok = s_axi_wvalid && s_axi_wready;
			b_ok = s_axi_bvalid;
			br = s_axi_bresp;
			@(posedge clock);
			if (aw_ok) s_axi_awvalid <= 1'b0;
			if (w_ok) s_axi_wvalid <= 1'b0;
			if (b_ok) begin
				s_axi_bready <= 1'b0;
				check(br, resp_okay);
				return;
			end
		end
		errors++;
		end_sim();
	endtask : wr

	// The answer is judged from what stood 1 ns after the previous edge, so
	// the register update at the edge itself cannot race the check.
	task automatic rd(input logic [3:0] a);
		logic ok, v;
		@(posedge clock);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			#1;
			ok = s_axi_arvalid && s_axi_arready;
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clock);
			if (ok) s_axi_arvalid <= 1'b0;
			if (!ok && v) begin
				s_axi_rready <= 1'b0;
				return;
			end
		end
		errors++;
		end_sim();
	endtask : rd

	task automatic pulse(input logic [3:0] v);
		@(posedge clock);
		req <= v;
		@(posedge clock);
		req <= 4'h0;
	endtask : pulse

	task automatic wait_ev(input int k);
		for (int n = 0; n < 40; n++) begin
			@(posedge clock);
			#1;
			if (ev[k] === 1'b1) return;
		end
		errors++;
		end_sim();
	endtask : wait_ev

	////////////////////////////////////////////////////////////////////////
	initial begin
		{clock, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
		{s_axi_rready, rtc_wake, rtc_stop2_wake_enable, debug_enable} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, req} = 0;
		s_axi_wstrb = 4'hf;
		rst = 1'b1;
		reset_pin_n = 1'b1;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		rd(ctrl_addr);
		check(d, 32'h1);
		rd(4'hc);
		check({d, r}, {32'h0, resp_slverr});
		$display("test reset done");
		wr(ctrl_addr, 32'h0);
		pulse(4'h1);
		wait_ev(3);
		check(stop_mode, 2'h0);
		$display("test stop disabled done");
		wr(ctrl_addr, 32'h3e1);
		pulse(4'h1);
		wait_ev(1);
		check({bus_clock_en, cpu_clock_en, periph_clock_en}, 3'h0);
		check({regulator_active, ram_only_power}, 2'h0);
		check({int_ref_run, ext_osc_run}, 2'h2);
		pulse(4'h2);
		wait_ev(5);
		check({stop_mode, por_reset}, 3'h0);
		$display("test stop3 interrupt done");
		debug_enable <= 1'b1;
		wr(ctrl_addr, 32'h11);
		pulse(4'h1);
		wait_ev(1);
		check({debug_clock_en, regulator_active, periph_clock_en}, 3'h6);
		pulse(4'h8);
		wait_ev(7);
		check({debug_cmd_status, stop_mode}, {dbg_err_stopped, 2'h1});
		pulse(4'h4);
		wait_ev(6);
		check(stop_mode, 2'h0);
		debug_enable <= 1'b0;
		$display("test debug stop done");
		wr(ctrl_addr, 32'hf9d);
		pulse(4'h1);
		wait_ev(1);
		check({regulator_active, adc_run_in_stop, analog_comparator_bandgap_in_stop}, 3'h7);
		check({ext_osc_run, int_ref_run}, 2'h2);
		@(posedge clock) reset_pin_n <= 1'b0;
		wait_ev(4);
		check(stop_mode, 2'h0);
		@(posedge clock) reset_pin_n <= 1'b1;
		$display("test detector stop done");
		wr(ctrl_addr, 32'h11);
		pulse(4'h1);
		wait_ev(2);
		check({ram_only_power, pin_latch, bus_clock_en}, 3'h6);
		@(posedge clock) rtc_wake <= 1'b1;
		repeat (8) @(posedge clock);
		check(stop_mode, 2'h2);
		rtc_stop2_wake_enable <= 1'b1;
		wait_ev(4);
		@(posedge clock) rtc_wake <= 1'b0;
		rtc_stop2_wake_enable <= 1'b0;
		rd(ctrl_addr);
		check(d, 32'h1);
		rd(status_addr);
		check(d, 32'hc);
		// Port registers would be restored from RAM here, before the ack.
		wr(ack_addr, 32'h1);
		check({partial_powerdown_flag, pin_latch}, 2'h0);
		$display("test stop2 recovery done");
		end_sim();
	end
endmodule : stop_mode_controller_bench
